// ==== rtl/sau_pkg.sv ====
// What this block does
// RL1 - Set sticky saturation flag when a clamped result differs from its input.
// RL2 - Flag cleared only by status write instruction; status read returns it.
// RL3 - Unsigned clamp sends negative inputs to zero, in-range inputs pass unchanged.
// RL4 - Signed word clamp shifts first, then clamps to signed n-bit range.
// RL5 - Unsigned word clamp shifts first, then clamps to zero..2^n-1.
// RL6 - Word width n is 1..32 signed, 0..31 unsigned.
// RL7 - Optional pre-shift: arithmetic right 1..31 or logical left 0..31.
// RL8 - Dual-half clamps each lane alone; n is 1..16 signed, 0..15 unsigned.
// RL9 - Dual-half results go to matching halfwords, signed or unsigned lanes.
// RL10 - No saturating operation touches the N, Z, C or V flags.
// RL11 - Word add/sub clamps the 32-bit signed result and sets flag on clamp.
// RL12 - Byte add/sub: four 8-bit lanes, each clamped signed, to matching byte.
// RL13 - Half add/sub: two 16-bit lanes, each clamped signed, to matching half.
// RL14 - Byte and half lane add/sub never change the sticky flag.
// RL15 - With no destination given, result goes back to first operand register; clamp ops always write dest_idx.
// RL16 - Add-sub exchange: top = a.top+b.bot, bottom = a.bot-b.top, clamped 16-bit.
// RL17 - Sub-add exchange: top = a.top-b.bot, bottom = a.bot+b.top, clamped 16-bit.
// RL18 - Software never names stack pointer or program counter as operand.
// RL19 - Condition false suppresses writeback and any sticky flag update.
package sau_pkg;
  typedef enum logic [3:0] {
    SAU_OP_SIGNED_WIDTH_CLAMP,
    SAU_OP_UNSIGNED_WIDTH_CLAMP,
    SAU_OP_SIGNED_DUAL_HALF_CLAMP,
    SAU_OP_UNSIGNED_DUAL_HALF_CLAMP,
    SAU_OP_SAT_ADD_WORD,
    SAU_OP_SAT_SUB_WORD,
    SAU_OP_SAT_ADD_BYTES,
    SAU_OP_SAT_SUB_BYTES,
    SAU_OP_SAT_ADD_HALVES,
    SAU_OP_SAT_SUB_HALVES,
    SAU_OP_SAT_ADD_SUB_EXCHANGE,
    SAU_OP_SAT_SUB_ADD_EXCHANGE
  } sau_op_t;

  typedef enum logic [1:0] {
    SAU_SHIFT_NONE,
    SAU_SHIFT_ARITH_RIGHT,
    SAU_SHIFT_LOGICAL_LEFT
  } sau_shift_t;

  localparam int unsigned SAU_WORD_W  = 32;
  localparam int unsigned SAU_HALF_W  = 16;
  localparam int unsigned SAU_BYTE_W  = 8;
  localparam int unsigned SAU_WIDE_W  = 64;
  localparam int unsigned SAU_REG_W   = 4;
  localparam int unsigned SAU_N_W     = 6;
  localparam int unsigned SAU_SH_W    = 5;
  localparam logic        SAU_Q_RST   = 1'b0;
  localparam logic [31:0] SAU_RES_RST = 32'h0000_0000;
  localparam logic [3:0]  SAU_REG_RST = 4'h0;
endpackage : sau_pkg

// ==== rtl/sau_clamp.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Clamp a 64-bit signed value to a signed or unsigned n-bit range
module sau_clamp (
  input  wire logic signed [63:0] value,
  input  wire logic [5:0]         width_n,
  input  wire logic               is_signed,
  output logic [31:0]             result,
  output logic                    saturated
);
  logic signed [63:0] hi_lim;
  logic signed [63:0] lo_lim;
  logic               below;
  logic               above;

  // Signed: [-2^(n-1), 2^(n-1)-1]; unsigned: [0, 2^n-1]
  assign hi_lim = is_signed
                  ? ((64'sh1 <<< (width_n - 6'h1)) - 64'sh1)  // [RL4]
                  : ((64'sh1 <<< width_n) - 64'sh1);          // [RL5]
  assign lo_lim = is_signed ? -(64'sh1 <<< (width_n - 6'h1)) : 64'sh0;  // [RL3]
  assign below  = value < lo_lim;
  assign above  = value > hi_lim;
  assign result = below ? lo_lim[31:0] : (above ? hi_lim[31:0] : value[31:0]);
  assign saturated = below | above;  // [RL1]
endmodule : sau_clamp
`default_nettype wire

// ==== rtl/sau_lane.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Signed saturating add or subtract of one lane of width W
module sau_lane #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         subtract,
  output logic [W-1:0]      result,
  output logic              saturated
);
  logic signed [W:0] sum;
  logic              pos_ovf;
  logic              neg_ovf;

  assign sum = subtract ? ($signed({a[W-1], a}) - $signed({b[W-1], b}))
                        : ($signed({a[W-1], a}) + $signed({b[W-1], b}));
  assign pos_ovf = ~sum[W] & sum[W-1];
  assign neg_ovf = sum[W] & ~sum[W-1];
  assign result = pos_ovf ? {1'b0, {(W-1){1'b1}}}
                : (neg_ovf ? {1'b1, {(W-1){1'b0}}} : sum[W-1:0]);
  assign saturated = pos_ovf | neg_ovf;
endmodule : sau_lane
`default_nettype wire

// ==== rtl/sau_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Saturating arithmetic execution unit, one result per issued cycle whose condition passes
module sau_top (
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  input  wire logic                issue_valid,
  input  wire sau_pkg::sau_op_t    issue_op,
  input  wire logic                cond_pass,
  input  wire logic [31:0]         first_operand_reg,
  input  wire logic [31:0]         second_operand_reg,
  input  wire logic [3:0]          first_operand_idx,
  input  wire logic [3:0]          dest_idx,
  input  wire logic                dest_given,
  input  wire logic [5:0]          width_n,
  input  wire sau_pkg::sau_shift_t shift_kind,
  input  wire logic [4:0]          shift_amount,
  input  wire logic                status_reg_write_instr,
  input  wire logic                status_wr_q,
  input  wire logic                status_reg_read_instr,
  output logic                     wb_valid_ff,
  output logic [3:0]               wb_idx_ff,
  output logic [31:0]              wb_data_ff,
  output logic                     status_rd_valid_ff,
  output logic                     status_rd_q_ff,
  output logic                     sticky_q_ff
);
  // ==========================================================
  // Decode
  logic is_word_clamp;
  logic is_half_clamp;
  logic clamp_signed;
  logic is_word_arith;
  logic is_lane_arith;
  logic is_sub;
  logic lane_bytes;
  logic is_exchange;
  logic accept;

  assign is_word_clamp = (issue_op == sau_pkg::SAU_OP_SIGNED_WIDTH_CLAMP)
                       | (issue_op == sau_pkg::SAU_OP_UNSIGNED_WIDTH_CLAMP);
  assign is_half_clamp = (issue_op == sau_pkg::SAU_OP_SIGNED_DUAL_HALF_CLAMP)
                       | (issue_op == sau_pkg::SAU_OP_UNSIGNED_DUAL_HALF_CLAMP);
  assign clamp_signed  = (issue_op == sau_pkg::SAU_OP_SIGNED_WIDTH_CLAMP)
                       | (issue_op == sau_pkg::SAU_OP_SIGNED_DUAL_HALF_CLAMP);
  assign is_word_arith = (issue_op == sau_pkg::SAU_OP_SAT_ADD_WORD)
                       | (issue_op == sau_pkg::SAU_OP_SAT_SUB_WORD);
  assign is_exchange   = (issue_op == sau_pkg::SAU_OP_SAT_ADD_SUB_EXCHANGE)
                       | (issue_op == sau_pkg::SAU_OP_SAT_SUB_ADD_EXCHANGE);
  assign lane_bytes    = (issue_op == sau_pkg::SAU_OP_SAT_ADD_BYTES)
                       | (issue_op == sau_pkg::SAU_OP_SAT_SUB_BYTES);
  assign is_lane_arith = lane_bytes | is_exchange
                       | (issue_op == sau_pkg::SAU_OP_SAT_ADD_HALVES)
                       | (issue_op == sau_pkg::SAU_OP_SAT_SUB_HALVES);
  assign is_sub        = (issue_op == sau_pkg::SAU_OP_SAT_SUB_WORD)
                       | (issue_op == sau_pkg::SAU_OP_SAT_SUB_BYTES)
                       | (issue_op == sau_pkg::SAU_OP_SAT_SUB_HALVES);
  assign accept        = issue_valid & cond_pass;  // [RL19]

  // ==========================================================
  // Pre-shift and whole-word clamp
  logic signed [63:0] shifted;
  logic [31:0]        word_clamp_res;
  logic               word_clamp_sat;

  assign shifted = (shift_kind == sau_pkg::SAU_SHIFT_ARITH_RIGHT)
                   ? (64'(signed'(first_operand_reg)) >>> shift_amount)   // [RL7]
                   : (shift_kind == sau_pkg::SAU_SHIFT_LOGICAL_LEFT)
                   ? (64'(signed'(first_operand_reg)) <<< shift_amount)   // [RL7]
                   : 64'(signed'(first_operand_reg));

  // Width range per [RL6] is the issuer's duty; unsigned n=0 clamps to 0
  sau_clamp u_word_clamp (
    .value     (shifted),
    .width_n   (width_n),
    .is_signed (clamp_signed),
    .result    (word_clamp_res),
    .saturated (word_clamp_sat)
  );

  // ==========================================================
  // Per-halfword clamp
  logic [15:0] half_clamp_res [2];
  logic [1:0]  half_clamp_sat;
  logic [31:0] half_lane_full [2];

  for (genvar h = 0; h < 2; h++) begin : g_half_clamp
    sau_clamp u_half_clamp (
      .value     (64'(signed'(first_operand_reg[16*h +: 16]))),
      .width_n   (width_n),
      .is_signed (clamp_signed),
      .result    (half_lane_full[h]),
      .saturated (half_clamp_sat[h])
    );
    assign half_clamp_res[h] = half_lane_full[h][15:0];  // [RL8]
  end

  // ==========================================================
  // Word add and subtract
  logic [31:0] word_arith_res;
  logic        word_arith_sat;

  sau_lane #(.W(sau_pkg::SAU_WORD_W)) u_word_lane (
    .a         (first_operand_reg),
    .b         (second_operand_reg),
    .subtract  (is_sub),
    .result    (word_arith_res),  // [RL11]
    .saturated (word_arith_sat)
  );

  // ==========================================================
  // Byte lanes, halfword lanes and exchange forms
  logic [31:0] byte_res;
  logic [31:0] half_res;
  logic [15:0] half_a [2];
  logic [15:0] half_b [2];
  logic [1:0]  half_sub;

  for (genvar i = 0; i < 4; i++) begin : g_byte
    sau_lane #(.W(sau_pkg::SAU_BYTE_W)) u_byte_lane (
      .a         (first_operand_reg[8*i +: 8]),
      .b         (second_operand_reg[8*i +: 8]),
      .subtract  (is_sub),
      .result    (byte_res[8*i +: 8]),  // [RL12]
      .saturated ()
    );
  end

  // Exchange forms pair each half of the first with the opposite half of the second
  assign half_a[0] = first_operand_reg[15:0];
  assign half_a[1] = first_operand_reg[31:16];
  assign half_b[0] = is_exchange ? second_operand_reg[31:16] : second_operand_reg[15:0];
  assign half_b[1] = is_exchange ? second_operand_reg[15:0] : second_operand_reg[31:16];
  assign half_sub[1] = (issue_op == sau_pkg::SAU_OP_SAT_SUB_ADD_EXCHANGE)  // [RL17]
                     | (~is_exchange & is_sub);
  assign half_sub[0] = (issue_op == sau_pkg::SAU_OP_SAT_ADD_SUB_EXCHANGE)  // [RL16]
                     | (~is_exchange & is_sub);

  for (genvar j = 0; j < 2; j++) begin : g_half
    sau_lane #(.W(sau_pkg::SAU_HALF_W)) u_half_lane (
      .a         (half_a[j]),
      .b         (half_b[j]),
      .subtract  (half_sub[j]),
      .result    (half_res[16*j +: 16]),  // [RL13]
      .saturated ()
    );
  end

  // ==========================================================
  // Result select and flag event
  logic [31:0] result_sel;
  logic        sat_event;
  logic [3:0]  wb_target;

  assign result_sel = is_word_clamp ? word_clamp_res
                    : is_half_clamp ? {half_clamp_res[1], half_clamp_res[0]}  // [RL9]
                    : is_word_arith ? word_arith_res
                    : lane_bytes    ? byte_res
                    : half_res;
  // Lane add/sub never raise the flag; no N/Z/C/V output exists at all [RL14] [RL10]
  assign sat_event = accept & ((is_word_clamp & word_clamp_sat)
                             | (is_half_clamp & (|half_clamp_sat))
                             | (is_word_arith & word_arith_sat));  // [RL1]
  assign wb_target = (is_lane_arith | is_word_arith) & ~dest_given
                     ? first_operand_idx : dest_idx;  // [RL15]

  // ==========================================================
  // Registers
  logic nxt_sticky_q;

  // Saturation set wins over a same-cycle clear
  assign nxt_sticky_q = sat_event ? 1'b1                          // [RL1]
                      : status_reg_write_instr ? status_wr_q      // [RL2]
                      : sticky_q_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sticky_q_ff        <= sau_pkg::SAU_Q_RST;
      wb_valid_ff        <= 1'b0;
      wb_idx_ff          <= sau_pkg::SAU_REG_RST;
      wb_data_ff         <= sau_pkg::SAU_RES_RST;
      status_rd_valid_ff <= 1'b0;
      status_rd_q_ff     <= sau_pkg::SAU_Q_RST;
    end else begin
      sticky_q_ff        <= nxt_sticky_q;
      wb_valid_ff        <= accept;  // [RL19]
      wb_idx_ff          <= accept ? wb_target : wb_idx_ff;
      wb_data_ff         <= accept ? result_sel : wb_data_ff;
      status_rd_valid_ff <= status_reg_read_instr;
      status_rd_q_ff     <= status_reg_read_instr ? sticky_q_ff : status_rd_q_ff;  // [RL2]
    end
  end
endmodule : sau_top
`default_nettype wire

// ==== sim/sau_top_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module sau_top_chk (
  input wire logic             sys_clk,
  input wire logic             rst_b,
  input wire logic             issue_valid,
  input wire sau_pkg::sau_op_t issue_op,
  input wire logic             cond_pass,
  input wire logic [31:0]      first_operand_reg,
  input wire logic [31:0]      second_operand_reg,
  input wire logic [3:0]       first_operand_idx,
  input wire logic             dest_given,
  input wire logic             status_reg_write_instr,
  input wire logic             status_wr_q,
  input wire logic             status_reg_read_instr,
  input wire logic             wb_valid_ff,
  input wire logic [3:0]       wb_idx_ff,
  input wire logic [31:0]      wb_data_ff,
  input wire logic             status_rd_valid_ff,
  input wire logic             status_rd_q_ff,
  input wire logic             sticky_q_ff
);
  // ==========================================================
  // Accepted operation decode
  wire        acc = issue_valid & cond_pass;
  wire        lane = acc & (issue_op inside {[sau_pkg::SAU_OP_SAT_ADD_BYTES:sau_pkg::SAU_OP_SAT_SUB_HALVES]});
  wire        arith = acc & (issue_op >= sau_pkg::SAU_OP_SAT_ADD_WORD);
  wire [31:0] sum = first_operand_reg + second_operand_reg;
  wire        ovf = acc & (issue_op == sau_pkg::SAU_OP_SAT_ADD_WORD) & sum[31]
                    & ~first_operand_reg[31] & ~second_operand_reg[31];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Properties
  property p_idx; arith && !dest_given |=> wb_valid_ff && wb_idx_ff == $past(first_operand_idx); endproperty
  a_idx: assert property (p_idx) else $error("default destination wrong");
  property p_nowb; !acc |=> !wb_valid_ff; endproperty
  a_nowb: assert property (p_nowb) else $error("writeback without accepted op");
  property p_hold; !acc && !status_reg_write_instr |=> $stable(sticky_q_ff); endproperty
  a_hold: assert property (p_hold) else $error("sticky flag moved with no cause");
  property p_lane; lane && !status_reg_write_instr |=> $stable(sticky_q_ff); endproperty
  a_lane: assert property (p_lane) else $error("lane op changed sticky flag");
  property p_wr; status_reg_write_instr && !acc |=> sticky_q_ff == $past(status_wr_q); endproperty
  a_wr: assert property (p_wr) else $error("status write not loaded");
  property p_fall; $fell(sticky_q_ff) |-> $past(status_reg_write_instr); endproperty
  a_fall: assert property (p_fall) else $error("sticky flag cleared by an op");
  property p_rd; status_reg_read_instr |=> status_rd_valid_ff && status_rd_q_ff == $past(sticky_q_ff); endproperty
  a_rd: assert property (p_rd) else $error("status read wrong");
  property p_ovf; ovf |=> wb_data_ff == 32'h7fff_ffff && sticky_q_ff; endproperty
  a_ovf: assert property (p_ovf) else $error("word add overflow not clamped");
  cover property (ovf);
  cover property (lane);
  cover property (status_reg_write_instr && !status_wr_q);
endmodule : sau_top_chk
bind sau_top sau_top_chk sau_top_chk_i (.*);
`default_nettype wire

// ==== sim/sau_issue_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module sau_issue_model (
  input  wire logic                 sys_clk,
  output var logic                  issue_valid,
  output var sau_pkg::sau_op_t      issue_op,
  output var logic                  cond_pass,
  output var logic [31:0]           first_operand_reg,
  output var logic [31:0]           second_operand_reg,
  output var logic [3:0]            first_operand_idx,
  output var logic [3:0]            dest_idx,
  output var logic                  dest_given,
  output var logic [5:0]            width_n,
  output var sau_pkg::sau_shift_t   shift_kind,
  output var logic [4:0]            shift_amount,
  output var logic                  status_reg_write_instr,
  output var logic                  status_wr_q,
  output var logic                  status_reg_read_instr
);
  initial begin
    {issue_valid, cond_pass, dest_given, status_reg_write_instr, status_wr_q, status_reg_read_instr} = 6'h00;
    issue_op = sau_pkg::SAU_OP_SAT_ADD_WORD;
    shift_kind = sau_pkg::SAU_SHIFT_NONE;
    {first_operand_reg, second_operand_reg, width_n, shift_amount} = 75'h0;
    first_operand_idx = 4'h3;
    dest_idx = 4'h5;
  end
  task send(input sau_pkg::sau_op_t op, input logic c, dg, input logic [31:0] a, b,
            input logic [5:0] n, input sau_pkg::sau_shift_t sk, input logic [4:0] sa);
    @(negedge sys_clk);
    issue_valid = 1'h1;
    cond_pass = c;
    issue_op = op;
    dest_given = dg;
    first_operand_reg = a;
    second_operand_reg = b;
    width_n = n;
    shift_kind = sk;
    shift_amount = sa;
    @(negedge sys_clk);
    issue_valid = 1'h0;
    // Released operand buses show fresh values
    first_operand_reg = ~a;
    second_operand_reg = ~b;
  endtask : send
  task st(input logic wr, q, rd);
    @(negedge sys_clk);
    status_reg_write_instr = wr;
    status_wr_q = q;
    status_reg_read_instr = rd;
    @(negedge sys_clk);
    status_reg_write_instr = 1'h0;
    status_reg_read_instr = 1'h0;
  endtask : st
endmodule : sau_issue_model
`default_nettype wire

// ==== sim/saturating_arith_unit_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module saturating_arith_unit_test;
  logic                sys_clk = 1'h0;
  logic                rst_b = 1'h0;
  wire logic           issue_valid, cond_pass, dest_given, status_reg_write_instr, status_wr_q, status_reg_read_instr;
  wire sau_pkg::sau_op_t    issue_op;
  wire sau_pkg::sau_shift_t shift_kind;
  wire logic [31:0]    first_operand_reg, second_operand_reg;
  wire logic [3:0]     first_operand_idx, dest_idx;
  wire logic [5:0]     width_n;
  wire logic [4:0]     shift_amount;
  logic                wb_valid_ff, status_rd_valid_ff, status_rd_q_ff, sticky_q_ff;
  logic [3:0]          wb_idx_ff;
  logic [31:0]         wb_data_ff;
  int                  fail_count = 0;
  int                  num_checks = 0;
  sau_issue_model sau_issue_model_i (.*);
  sau_top sau_top_i (.*);
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  task close_out;
    if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task chk(input string name, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : chk
  task run(input sau_pkg::sau_op_t op, input logic c, dg, input logic [31:0] a, b, input logic [5:0] n,
           input sau_pkg::sau_shift_t sk, input logic [4:0] sa, input logic [31:0] e, input logic eq);
    sau_issue_model_i.send(op, c, dg, a, b, n, sk, sa);
    chk("wb_valid", {31'h0, c}, {31'h0, wb_valid_ff});
    if (c) chk("wb_data", e, wb_data_ff);
    if (c) chk("wb_idx", (dg || op < sau_pkg::SAU_OP_SAT_ADD_WORD) ? 32'h5 : 32'h3, {28'h0, wb_idx_ff});
    if (eq !== 1'bz) chk("sticky", {31'h0, eq}, {31'h0, sticky_q_ff});
  endtask : run
  task rc(input sau_pkg::sau_op_t op, input logic [31:0] a, input logic [5:0] n,
          input sau_pkg::sau_shift_t sk, input logic [4:0] sa, input logic [31:0] e, input logic eq);
    run(op, 1'h1, 1'h1, a, 32'h0, n, sk, sa, e, eq);
  endtask : rc
  task ra(input sau_pkg::sau_op_t op, input logic dg, input logic [31:0] a, b, e, input logic eq);
    run(op, 1'h1, dg, a, b, 6'h00, sau_pkg::SAU_SHIFT_NONE, 5'h00, e, eq);
  endtask : ra
  task t_word;
    sau_issue_model_i.st(1'h1, 1'h0, 1'h0);
    rc(sau_pkg::SAU_OP_SIGNED_WIDTH_CLAMP, 32'h8000_0000, 6'h20, sau_pkg::SAU_SHIFT_ARITH_RIGHT, 5'h04,
       32'hf800_0000, 1'h0);
    rc(sau_pkg::SAU_OP_UNSIGNED_WIDTH_CLAMP, 32'h7fff_ffff, 6'h1f, sau_pkg::SAU_SHIFT_NONE, 5'h00,
       32'h7fff_ffff, 1'h0);
    rc(sau_pkg::SAU_OP_SIGNED_WIDTH_CLAMP, 32'h0000_1000, 6'h10, sau_pkg::SAU_SHIFT_LOGICAL_LEFT, 5'h04,
       32'h0000_7fff, 1'h1);
    rc(sau_pkg::SAU_OP_UNSIGNED_WIDTH_CLAMP, 32'hffff_fff0, 6'h07, sau_pkg::SAU_SHIFT_NONE, 5'h00,
       32'h0, 1'h1);
  endtask : t_word
  task t_dual;
    sau_issue_model_i.st(1'h1, 1'h0, 1'h0);
    rc(sau_pkg::SAU_OP_SIGNED_DUAL_HALF_CLAMP, 32'h7000_ff00, 6'h09, sau_pkg::SAU_SHIFT_NONE, 5'h00,
       32'h00ff_ff00, 1'h1);
    rc(sau_pkg::SAU_OP_UNSIGNED_DUAL_HALF_CLAMP, 32'h0180_8000, 6'h08, sau_pkg::SAU_SHIFT_NONE, 5'h00,
       32'h00ff_0000, 1'h1);
  endtask : t_dual
  task t_lanes;
    sau_issue_model_i.st(1'h1, 1'h0, 1'h0);
    ra(sau_pkg::SAU_OP_SAT_ADD_BYTES, 1'h1, 32'h7f80_0102, 32'h01ff_0304, 32'h7f80_0406, 1'h0);
    ra(sau_pkg::SAU_OP_SAT_SUB_BYTES, 1'h0, 32'h8000_7f00, 32'h0100_ff00, 32'h8000_7f00, 1'h0);
    ra(sau_pkg::SAU_OP_SAT_ADD_HALVES, 1'h1, 32'h7fff_8000, 32'h0001_ffff, 32'h7fff_8000, 1'h0);
    ra(sau_pkg::SAU_OP_SAT_SUB_HALVES, 1'h1, 32'h8000_0005, 32'h0001_0003, 32'h8000_0002, 1'h0);
    ra(sau_pkg::SAU_OP_SAT_ADD_SUB_EXCHANGE, 1'h0, 32'h7fff_0005, 32'h0003_0001, 32'h7fff_0002, 1'bz);
    ra(sau_pkg::SAU_OP_SAT_SUB_ADD_EXCHANGE, 1'h1, 32'h8000_0005, 32'h0003_0001, 32'h8000_0008, 1'bz);
  endtask : t_lanes
  task t_add;
    sau_issue_model_i.st(1'h1, 1'h0, 1'h0);
    ra(sau_pkg::SAU_OP_SAT_ADD_WORD, 1'h1, 32'h0000_0005, 32'hffff_fffe, 32'h0000_0003, 1'h0);
    ra(sau_pkg::SAU_OP_SAT_ADD_WORD, 1'h0, 32'h7fff_ffff, 32'h0000_0001, 32'h7fff_ffff, 1'h1);
    ra(sau_pkg::SAU_OP_SAT_SUB_WORD, 1'h1, 32'h8000_0000, 32'h0000_0001, 32'h8000_0000, 1'h1);
  endtask : t_add
  task t_flag;
    sau_issue_model_i.st(1'h1, 1'h1, 1'h0);
    chk("sticky", 32'h1, {31'h0, sticky_q_ff});
    sau_issue_model_i.st(1'h0, 1'h0, 1'h1);
    chk("rd_q", 32'h3, {30'h0, status_rd_valid_ff, status_rd_q_ff});
    sau_issue_model_i.st(1'h1, 1'h0, 1'h0);
    run(sau_pkg::SAU_OP_SIGNED_WIDTH_CLAMP, 1'h0, 1'h1, 32'h7fff_ffff, 32'h0, 6'h08,
        sau_pkg::SAU_SHIFT_NONE, 5'h00, 32'h0, 1'h0);
  endtask : t_flag
  initial begin
    repeat (20) @(negedge sys_clk);
    rst_b = 1'h1;
    t_word();
    t_dual();
    t_lanes();
    t_add();
    t_flag();
    close_out();
  end
  initial begin
    #(50 * 2000);
    fail_count++;
    close_out();
  end
endmodule : saturating_arith_unit_test
`default_nettype wire
